// File: tweep_pkg.sv
// Constants and types shared by the two-wire memory slave
package tweep_pkg;
    // ****************************************
    // Addressing
    // ****************************************
    localparam int ADDR_W = 15;
    localparam int PAGE_BITS = 6;
    localparam int MEM_DEPTH = 32768;
    localparam logic [3:0] DEV_TYPE_CODE = 4'h5; // Arbitrary neutral value
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_RST = 3'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [5:0] PAGE_CNT_RST = 6'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 50000000;
    localparam int WRITE_CYCLE_TIME_US = 5000;
    localparam int WRITE_CYCLE_CYC = (CLK_HZ / 1000000) * WRITE_CYCLE_TIME_US;
    localparam int WC_CNT_W = 20;
    localparam logic [WC_CNT_W-1:0] WC_CNT_RST = 20'h00000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_RDATA,
        ST_RACK
    } tweep_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } tweep_line_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } tweep_evt_t;
endpackage

// File: tweep_slave.sv
// Two-wire serial slave with byte-organised memory and self-timed write cycle

// Behaviour
// - SDA change while SCL high is start/stop
// - SDA falling with SCL high is start
// - SDA rising with SCL high is stop
// - Stop after read returns to standby
// - Acknowledge each received byte in ninth clock
// - Standby at reset and after stop
// - Recovery: clocks then start resume decoding
// - Top four address bits must match type
// - Address LSB selects read or write
// - Match acknowledges, mismatch returns to standby
// - Two word-address bytes then data, each acknowledged
// - Stop ends write, starts self-timed cycle
// - Write cycle timed from stop
// - Page write up to sixty-four bytes
// - Write increments low six bits only
// - Polling acknowledged only after write completes
// - Current, random and sequential reads
// - Address counter holds last address plus one
// - Read address wraps at memory end
// - Read sends byte at counter address
// - Sample on SCL rise, launch after fall
// - SDA driven open-drain only
// - Fifteen-bit address, sixty-four-byte pages
// - Sequential read continues while controller acknowledges
module tweep_slave #(
    parameter int WRITE_CYCLE_CYCLES = tweep_pkg::WRITE_CYCLE_CYC
) (
    input wire logic i_mclk, // System clock
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic i_scl, // Serial clock pin
    input wire logic i_sda, // Serial data pin level
    output logic o_sda, // Serial data output value, always low
    output logic o_sda_oe_n, // Low while pulling SDA low
    output logic o_busy // Self-timed write cycle running
);
    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    tweep_pkg::tweep_line_t meta_q, meta_d;
    tweep_pkg::tweep_line_t sync_q, sync_d;
    tweep_pkg::tweep_line_t prev_q, prev_d;
    tweep_pkg::tweep_evt_t evt;

    always_comb begin
        meta_d = '{scl: i_scl, sda: i_sda};
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '{scl: 1'b1, sda: 1'b1};
            sync_q <= '{scl: 1'b1, sda: 1'b1};
            prev_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Edges seen one stage late, after the synchroniser
    always_comb begin
        evt.start = prev_q.scl && sync_q.scl && prev_q.sda && !sync_q.sda;
        evt.stop = prev_q.scl && sync_q.scl && !prev_q.sda && sync_q.sda;
        evt.rise = !prev_q.scl && sync_q.scl;
        evt.fall = prev_q.scl && !sync_q.scl;
    end

    // ****************************************
    // Memory array
    // ****************************************
    logic [7:0] mem [0:tweep_pkg::MEM_DEPTH-1];
    logic mem_we;
    logic [tweep_pkg::ADDR_W-1:0] mem_wa;
    logic [7:0] mem_wd;

    // One byte written as each data byte is acknowledged
    always_ff @(posedge i_mclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ****************************************
    // Protocol engine
    // ****************************************
    tweep_pkg::tweep_state_t state_q, state_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic ack_q, ack_d;
    logic rw_q, rw_d;
    logic drive_q, drive_d;
    logic [tweep_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [6:0] addr_hi_q, addr_hi_d;
    logic [5:0] page_cnt_q, page_cnt_d;
    logic pend_q, pend_d;
    logic busy_q, busy_d;
    logic [tweep_pkg::WC_CNT_W-1:0] wc_q, wc_d;
    logic [7:0] rd_byte;

    function automatic logic [tweep_pkg::ADDR_W-1:0] page_inc(
        input logic [tweep_pkg::ADDR_W-1:0] a
    );
        logic [tweep_pkg::PAGE_BITS-1:0] low;
        low = a[tweep_pkg::PAGE_BITS-1:0] + 6'h01;
        return {a[tweep_pkg::ADDR_W-1:tweep_pkg::PAGE_BITS], low};
    endfunction

    // Byte at the counter, loaded at each read launch
    assign rd_byte = mem[addr_q];

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        ack_d = ack_q;
        rw_d = rw_q;
        drive_d = drive_q;
        addr_d = addr_q;
        addr_hi_d = addr_hi_q;
        page_cnt_d = page_cnt_q;
        pend_d = pend_q;
        busy_d = busy_q;
        wc_d = wc_q;
        mem_we = 1'b0;
        mem_wa = addr_q;
        mem_wd = shift_q;
        if (busy_q) begin
            // Inputs ignored while the write cycle runs
            drive_d = 1'b0;
            state_d = tweep_pkg::ST_IDLE;
            if (wc_q >= tweep_pkg::WC_CNT_W'(WRITE_CYCLE_CYCLES - 1)) begin
                busy_d = 1'b0;
                wc_d = tweep_pkg::WC_CNT_RST;
            end else begin
                wc_d = wc_q + 20'h00001;
            end
        end else if (evt.start) begin
            state_d = tweep_pkg::ST_DEV;
            bit_d = tweep_pkg::BIT_RST;
            ack_d = 1'b0;
            drive_d = 1'b0;
            pend_d = 1'b0;
        end else if (evt.stop) begin
            state_d = tweep_pkg::ST_IDLE;
            drive_d = 1'b0;
            if (pend_q) begin
                busy_d = 1'b1;
                wc_d = tweep_pkg::WC_CNT_RST;
            end
            pend_d = 1'b0;
        end else if (state_q != tweep_pkg::ST_IDLE) begin
            if (evt.rise) begin
                if (ack_q) begin
                    if (state_q == tweep_pkg::ST_RACK) begin
                        // Released line ends the read, a pulled one asks for more
                        if (sync_q.sda) begin
                            state_d = tweep_pkg::ST_IDLE;
                        end else begin
                            state_d = tweep_pkg::ST_RDATA;
                        end
                    end
                end else if (state_q != tweep_pkg::ST_RDATA) begin
                    shift_d = {shift_q[6:0], sync_q.sda};
                    bit_d = bit_q + 3'h1;
                    if (bit_q == tweep_pkg::BIT_LAST) begin
                        ack_d = 1'b1;
                    end
                end else begin
                    bit_d = bit_q + 3'h1;
                    if (bit_q == tweep_pkg::BIT_LAST) begin
                        ack_d = 1'b1;
                        state_d = tweep_pkg::ST_RACK;
                        addr_d = addr_q + 15'h0001;
                    end
                end
            end else if (evt.fall) begin
                if (state_q == tweep_pkg::ST_RACK) begin
                    // Last data bit done: free the line for the controller's bit
                    drive_d = 1'b0;
                end else if (ack_q && !drive_q &&
                        state_q != tweep_pkg::ST_RDATA) begin
                    // Byte done: decide whether to acknowledge
                    case (state_q)
                        tweep_pkg::ST_DEV: begin
                            if (shift_q[7:4] == tweep_pkg::DEV_TYPE_CODE) begin
                                drive_d = 1'b1;
                                rw_d = shift_q[0];
                            end else begin
                                state_d = tweep_pkg::ST_IDLE;
                            end
                        end
                        tweep_pkg::ST_WDATA: begin
                            drive_d = 1'b1;
                            mem_we = 1'b1;
                            addr_d = page_inc(addr_q);
                            page_cnt_d = page_cnt_q + 6'h01;
                            pend_d = 1'b1;
                        end
                        default: begin
                            drive_d = 1'b1;
                        end
                    endcase
                end else if (ack_q && (drive_q || state_q == tweep_pkg::ST_RDATA)) begin
                    // Ninth clock done: move on
                    ack_d = 1'b0;
                    drive_d = 1'b0;
                    bit_d = tweep_pkg::BIT_RST;
                    case (state_q)
                        tweep_pkg::ST_DEV: begin
                            if (rw_q) begin
                                state_d = tweep_pkg::ST_RDATA;
                                shift_d = rd_byte;
                                drive_d = !rd_byte[7];
                            end else begin
                                state_d = tweep_pkg::ST_ADDR_HI;
                            end
                        end
                        tweep_pkg::ST_ADDR_HI: begin
                            addr_hi_d = shift_q[6:0];
                            state_d = tweep_pkg::ST_ADDR_LO;
                        end
                        tweep_pkg::ST_ADDR_LO: begin
                            addr_d = {addr_hi_q, shift_q};
                            page_cnt_d = tweep_pkg::PAGE_CNT_RST;
                            state_d = tweep_pkg::ST_WDATA;
                        end
                        tweep_pkg::ST_RDATA: begin
                            // Controller acknowledged: launch the next byte
                            shift_d = rd_byte;
                            drive_d = !rd_byte[7];
                        end
                        default: begin
                            state_d = state_q;
                        end
                    endcase
                end else if (state_q == tweep_pkg::ST_RDATA) begin
                    shift_d = {shift_q[6:0], 1'b0};
                    drive_d = !shift_q[6];
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= tweep_pkg::ST_IDLE;
            bit_q <= tweep_pkg::BIT_RST;
            shift_q <= tweep_pkg::BYTE_RST;
            ack_q <= 1'b0;
            rw_q <= 1'b0;
            drive_q <= 1'b0;
            addr_q <= tweep_pkg::ADDR_RST;
            addr_hi_q <= 7'h00;
            page_cnt_q <= tweep_pkg::PAGE_CNT_RST;
            pend_q <= 1'b0;
            busy_q <= 1'b0;
            wc_q <= tweep_pkg::WC_CNT_RST;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            ack_q <= ack_d;
            rw_q <= rw_d;
            drive_q <= drive_d;
            addr_q <= addr_d;
            addr_hi_q <= addr_hi_d;
            page_cnt_q <= page_cnt_d;
            pend_q <= pend_d;
            busy_q <= busy_d;
            wc_q <= wc_d;
        end
    end

    // ****************************************
    // Pin outputs
    // ****************************************
    logic sda_oe_n_q;
    logic sda_oe_n_d;
    always_comb begin
        sda_oe_n_d = !drive_d;
    end
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sda_oe_n_q <= 1'b1;
            o_sda <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            sda_oe_n_q <= sda_oe_n_d;
            o_sda <= 1'b0;
            o_busy <= busy_d;
        end
    end
    assign o_sda_oe_n = sda_oe_n_q;
endmodule

// File: tweep_slave_props.sv
// Port-level checks for the two-wire memory slave
module tweep_slave_props #(
    parameter int WRITE_CYCLE_CYCLES = 250000
) (
    input wire logic i_mclk, // System clock
    input wire logic i_rst_n, // Reset, active low
    input wire logic i_scl, // Serial clock pin
    input wire logic i_sda, // Resolved data line
    input wire logic o_sda, // Data output value
    input wire logic o_sda_oe_n, // Low while pulling data low
    input wire logic o_busy // Write cycle running
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sda_p_q;
    logic stop_evt;
    logic [7:0] stop_age_q;
    logic [7:0] stop_age_d;
    logic [19:0] busy_cnt_q;
    logic [19:0] busy_cnt_d;
    always_comb begin
        stop_evt = i_scl && i_sda && !sda_p_q;
        stop_age_d = stop_age_q == 8'hFF ? 8'hFF : stop_age_q + 8'h01;
        if (stop_evt) begin
            stop_age_d = 8'h00;
        end
        busy_cnt_d = o_busy ? busy_cnt_q + 20'h00001 : 20'h00000;
    end
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sda_p_q <= 1'b1;
            stop_age_q <= 8'hFF;
            busy_cnt_q <= 20'h00000;
        end else begin
            sda_p_q <= i_sda;
            stop_age_q <= stop_age_d;
            busy_cnt_q <= busy_cnt_d;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_sda_low_only: assert property (o_sda == 1'b0)
        else $error("data output not low");
    a_busy_silent: assert property (o_busy |-> o_sda_oe_n)
        else $error("line pulled during write cycle");
    a_busy_length: assert property ($fell(o_busy) |->
        busy_cnt_q >= 20'(WRITE_CYCLE_CYCLES - 1) && busy_cnt_q <= 20'(WRITE_CYCLE_CYCLES + 1))
        else $error("write cycle length off");
    a_drive_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
        else $error("data drive changed with clock high");
    a_ack_holds_high: assert property ($rose(i_scl) && !o_sda_oe_n |=> !o_sda_oe_n [*2])
        else $error("pulled level dropped during clock high");
    a_reset_idle: assert property ($rose(i_rst_n) |-> o_sda_oe_n && !o_busy)
        else $error("not idle after reset");
    a_start_releases: assert property (i_scl && $fell(i_sda) |-> ##[1:8] o_sda_oe_n)
        else $error("line held after start");
    a_busy_after_stop: assert property ($rose(o_busy) |-> stop_age_q <= 8'h0C)
        else $error("write cycle without stop");
    c_busy: cover property ($rose(o_busy));
    c_ack: cover property ($fell(o_sda_oe_n));
    c_stop: cover property (stop_evt);
endmodule

// File: tweep_ctl_model.sv
// Bus controller model driving the serial clock and data line
module tweep_ctl_model (
    input wire logic i_mclk, // Step timing clock
    input wire logic i_sda, // Resolved data line
    output logic o_scl, // Serial clock, idles high
    output logic o_sda_oe_n // Low while pulling data low
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // Data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        wait_n(2);
        o_sda_oe_n = b;
        wait_n(3);
        o_scl = 1'b1;
        wait_n(3);
        r = i_sda;
        o_scl = 1'b0;
    endtask
    // Falling data with clock high, from a released line
    task automatic start();
        wait_n(2);
        o_sda_oe_n = 1'b1;
        wait_n(2);
        o_scl = 1'b1;
        wait_n(3);
        o_sda_oe_n = 1'b0;
        wait_n(3);
        o_scl = 1'b0;
    endtask
    // Rising data with clock high
    task automatic stop();
        wait_n(2);
        o_sda_oe_n = 1'b0;
        wait_n(3);
        o_scl = 1'b1;
        wait_n(3);
        o_sda_oe_n = 1'b1;
        wait_n(4);
    endtask
    // Eight bits MSB first, then the ninth bit
    task automatic xfer(input logic [7:0] d, input logic ack_b, output logic [7:0] r,
                        output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(ack_b, a);
    endtask
endmodule

// File: tweep_slave_test.sv
// Self-checking bench for the two-wire memory slave
module tweep_slave_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WC = 200;
    localparam logic [3:0] DT = tweep_pkg::DEV_TYPE_CODE;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic scl;
    logic ctl_oe_n;
    logic o_sda;
    logic o_sda_oe_n;
    logic o_busy;
    wire logic sda_w;
    int mismatches = 0;
    int n_compared = 0;
    logic [7:0] mem [int];
    int ctr = 0;
    int base;
    logic [7:0] rd;
    logic ak;
    assign sda_w = ctl_oe_n & (o_sda_oe_n | o_sda);
    initial begin
        forever #10 i_mclk = ~i_mclk;
    end
    tweep_slave #(.WRITE_CYCLE_CYCLES(WC)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy));
    tweep_ctl_model ctl (.i_mclk(i_mclk), .i_sda(sda_w), .o_scl(scl), .o_sda_oe_n(ctl_oe_n));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic dev(input logic rw, input logic [3:0] code, input logic exp_a);
        ctl.start();
        ctl.xfer({code, 3'h0, rw}, 1'b1, rd, ak);
        chk("device ack", {7'h0, ak}, {7'h0, exp_a});
    endtask
    task automatic set_addr(input int a);
        dev(1'b0, DT, 1'b0);
        ctl.xfer(8'h80 | 8'(a >> 8), 1'b1, rd, ak);
        chk("high ack", {7'h0, ak}, 8'h00);
        ctl.xfer(8'(a), 1'b1, rd, ak);
        chk("low ack", {7'h0, ak}, 8'h00);
        ctr = a;
    endtask
    task automatic wr_bytes(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            ctl.xfer(d, 1'b1, rd, ak);
            chk("data ack", {7'h0, ak}, 8'h00);
            mem[ctr] = d;
            ctr = (ctr & 32'h7FC0) | ((ctr + 1) & 32'h3F);
        end
    endtask
    task automatic end_write();
        int k;
        ctl.stop();
        ctl.wait_n(8);
        chk("busy", {7'h0, o_busy}, 8'h01);
        dev(1'b0, DT, 1'b1);
        ctl.stop();
        for (k = 0; k < 2 * WC && o_busy !== 1'b0; k++) begin
            ctl.wait_n(1);
        end
        if (k == 2 * WC) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic rd_seq(input int n);
        for (int i = 0; i < n; i++) begin
            ctl.xfer(8'hFF, 1'(i == n - 1), rd, ak);
            chk("read data", rd, mem[ctr]);
            ctr = (ctr + 1) & 32'h7FFF;
        end
        ctl.stop();
    endtask
    initial begin
        repeat (100000) @(posedge i_mclk);
        mismatches++;
        test_done();
    end
    initial begin
        void'($urandom(24344));
        base = int'($urandom_range(510, 1)) << 6;
        repeat (16) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        ctl.wait_n(4);
        chk("idle drive", {7'h0, o_sda_oe_n}, 8'h01);
        chk("idle busy", {7'h0, o_busy}, 8'h00);
        dev(1'b0, DT ^ 4'h8, 1'b1);
        ctl.stop();
        $display("test reset and type mismatch done");
        set_addr(base);
        wr_bytes(65);
        end_write();
        $display("test page overrun and polling done");
        dev(1'b1, DT, 1'b0);
        rd_seq(1);
        set_addr(base);
        dev(1'b1, DT, 1'b0);
        rd_seq(64);
        $display("test current and sequential read done");
        set_addr(32'h7FFF);
        wr_bytes(1);
        end_write();
        set_addr(0);
        wr_bytes(1);
        end_write();
        set_addr(32'h7FFF);
        dev(1'b1, DT, 1'b0);
        rd_seq(2);
        $display("test memory end wrap done");
        test_done();
    end
endmodule
bind tweep_slave tweep_slave_props #(.WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)) u_props (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy));
